/* src/bpe_pkg.sv */
// Package: register map, field layout and event encodings of the bus event selector
package bpe_pkg;
  // Register byte offsets on the APB port
  localparam logic [7:0] OFF_ESEL_FIRST = 8'h00;
  localparam logic [7:0] OFF_ESEL_SECOND = 8'h04;
  localparam logic [7:0] OFF_CFG_BASE = 8'h10;
  localparam logic [7:0] OFF_CTR_BASE = 8'h20;
  localparam int NUM_CTR = 4;
  localparam int NUM_ESEL = 2;

  // Event selection field layout
  localparam int ESEL_CODE_LSB = 25;
  localparam int ESEL_MASK_LSB = 9;
  localparam logic [31:0] ESEL_RW_MASK = 32'h7fff_fe00;
  localparam logic [31:0] ESEL_RESET = 32'h0000_0000;

  // Counter configuration field layout
  localparam int CFG_SEL_LSB = 13;
  localparam int CFG_EN_BIT = 12;
  localparam logic [31:0] CFG_RW_MASK = 32'h0000_f000;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [2:0] BUS_CFG_SEL = 3'h3;

  // Event codes
  localparam logic [5:0] CODE_B2B = 6'h16;
  localparam logic [5:0] CODE_BNR = 6'h08;
  localparam logic [5:0] CODE_SNOOP = 6'h06;
  localparam logic [5:0] RESP_CODE_DEF = 6'h04;

  // Meaningful sub-event mask bits per event
  localparam logic [15:0] B2B_VALID = 16'h007e;
  localparam logic [15:0] BNR_VALID = 16'h0007;
  localparam logic [15:0] SNOOP_VALID = 16'h00c4;
  localparam logic [15:0] RESP_VALID = 16'h0306;

  function automatic logic [5:0] esel_code(input logic [31:0] sel);
    esel_code = sel[ESEL_CODE_LSB +: 6];
  endfunction : esel_code

  function automatic logic [15:0] esel_mask(input logic [31:0] sel);
    esel_mask = sel[ESEL_MASK_LSB +: 16];
  endfunction : esel_mask

  // Byte-lane write merge, writable bits only
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb, input logic [31:0] rw);
    logic [31:0] lane;
    lane = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & rw;
    merge = (old_v & ~lane) | (new_v & lane);
  endfunction : merge
endpackage : bpe_pkg

/* src/bpe_match_if.sv */
// Interface: one event selection value and its match result
`timescale 1ns/1ps
interface bpe_match_if;
  logic [31:0] sel;
  logic hit;
  modport ctl (output sel, input hit);
  modport mat (input sel, output hit);
endinterface : bpe_match_if

/* src/bpe_matcher.sv */
// Matcher: decodes one event selection value against the bus occurrence lines
`timescale 1ns/1ps
module bpe_matcher #(
  parameter logic [5:0] RESP_CODE = bpe_pkg::RESP_CODE_DEF
) (
  // Clock and reset, for checks only
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Selection and result
  bpe_match_if.mat m,
  // Occurrences, one line per sub-event bit
  input wire logic [15:0] b2b_occ_in,
  input wire logic [15:0] bnr_occ_in,
  input wire logic [15:0] snoop_occ_in,
  input wire logic [15:0] resp_occ_in
);
  logic [5:0] code;
  logic [15:0] mask;

  if (RESP_CODE == bpe_pkg::CODE_B2B || RESP_CODE == bpe_pkg::CODE_BNR ||
      RESP_CODE == bpe_pkg::CODE_SNOOP) begin : g_bad_code
    $error("response code collides with another event code");
  end

  always_comb begin
    code = bpe_pkg::esel_code(m.sel);
    mask = bpe_pkg::esel_mask(m.sel);
    if (code == bpe_pkg::CODE_B2B) begin
      m.hit = |(mask & b2b_occ_in & bpe_pkg::B2B_VALID);
    end else if (code == bpe_pkg::CODE_BNR) begin
      m.hit = |(mask & bnr_occ_in & bpe_pkg::BNR_VALID);
    end else if (code == bpe_pkg::CODE_SNOOP) begin
      m.hit = |(mask & snoop_occ_in & bpe_pkg::SNOOP_VALID);
    end else if (code == RESP_CODE) begin
      m.hit = |(mask & resp_occ_in & bpe_pkg::RESP_VALID);
    end else begin
      m.hit = 1'b0;
    end
  end

  b2b_hit_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (code == bpe_pkg::CODE_B2B) |-> (m.hit == |(mask & b2b_occ_in & 16'h007e)))
    else $error("b2b match wrong");
  bnr_ignore_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (code == bpe_pkg::CODE_BNR && (mask & bnr_occ_in & 16'h0007) == 16'h0000) |-> !m.hit)
    else $error("bnr counted an unmeaningful bit");
  snoop_hit_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (code == bpe_pkg::CODE_SNOOP) |-> (m.hit == |(mask & snoop_occ_in & 16'h00c4)))
    else $error("snoop match wrong");
  resp_hit_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (code == RESP_CODE) |-> (m.hit == |(mask & resp_occ_in & 16'h0306)))
    else $error("response match wrong");
  snoop_seen_c: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
    code == bpe_pkg::CODE_SNOOP && m.hit);
endmodule : bpe_matcher

/* src/bpe_top.sv */
// Top: APB register file, bus event selection and four bus event counters
`timescale 1ns/1ps
module bpe_top #(
  parameter int CNT_W = 32,
  parameter logic [5:0] RESP_CODE = bpe_pkg::RESP_CODE_DEF
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Bus occurrence lines from the bus unit
  input wire logic [15:0] b2b_occ_in,
  input wire logic [15:0] bnr_occ_in,
  input wire logic [15:0] snoop_occ_in,
  input wire logic [15:0] resp_occ_in,
  // Per-counter increment strobes
  output logic [3:0] ctr_tick_out
);
  typedef logic [CNT_W-1:0] bpe_cnt_t;

  if (CNT_W < 1 || CNT_W > 32) begin : g_bad_width
    $error("CNT_W must be 1 to 32");
  end

  logic [31:0] esel_r [bpe_pkg::NUM_ESEL];
  logic [31:0] esel_nxt [bpe_pkg::NUM_ESEL];
  logic [31:0] cfg_r [bpe_pkg::NUM_CTR];
  logic [31:0] cfg_nxt [bpe_pkg::NUM_CTR];
  bpe_cnt_t ctr_r [bpe_pkg::NUM_CTR];
  bpe_cnt_t ctr_nxt [bpe_pkg::NUM_CTR];
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [3:0] tick_r, tick_nxt;
  logic [3:0] inc;
  logic [3:0] wr_ctr;
  logic [1:0] hit;
  logic access, commit;
  logic [31:0] rd_val;
  logic map_ok;

  // One matcher per event selection register
  for (genvar g = 0; g < bpe_pkg::NUM_ESEL; g++) begin : g_match
    bpe_match_if mif ();
    assign mif.sel = esel_r[g];
    assign hit[g] = mif.hit;
    bpe_matcher #(.RESP_CODE(RESP_CODE)) u_match (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .m(mif.mat),
      .b2b_occ_in(b2b_occ_in),
      .bnr_occ_in(bnr_occ_in),
      .snoop_occ_in(snoop_occ_in),
      .resp_occ_in(resp_occ_in)
    );
  end

  // Counter k listens only to selector k/2 and only with select 3
  for (genvar k = 0; k < bpe_pkg::NUM_CTR; k++) begin : g_inc
    assign inc[k] = cfg_r[k][bpe_pkg::CFG_EN_BIT] &&
                    cfg_r[k][bpe_pkg::CFG_SEL_LSB +: 3] == bpe_pkg::BUS_CFG_SEL &&
                    hit[k / 2];
  end

  // Address decode and read mux
  always_comb begin
    rd_val = 32'h0000_0000;
    map_ok = 1'b0;
    if (paddr_in == bpe_pkg::OFF_ESEL_FIRST) begin
      rd_val = esel_r[0] & bpe_pkg::ESEL_RW_MASK;
      map_ok = 1'b1;
    end
    if (paddr_in == bpe_pkg::OFF_ESEL_SECOND) begin
      rd_val = esel_r[1] & bpe_pkg::ESEL_RW_MASK;
      map_ok = 1'b1;
    end
    for (int k = 0; k < bpe_pkg::NUM_CTR; k++) begin
      if (paddr_in == bpe_pkg::OFF_CFG_BASE + 8'(4 * k)) begin
        rd_val = cfg_r[k] & bpe_pkg::CFG_RW_MASK;
        map_ok = 1'b1;
      end
      if (paddr_in == bpe_pkg::OFF_CTR_BASE + 8'(4 * k)) begin
        rd_val = 32'(ctr_r[k]);
        map_ok = 1'b1;
      end
    end
  end

  // One wait state: pready rises in the second access cycle
  assign access = psel_in && penable_in;
  assign commit = access && pready_r && pwrite_in && map_ok;

  always_comb begin
    pready_nxt = access && !pready_r;
    pslverr_nxt = access && !pready_r && !map_ok;
    prdata_nxt = prdata_r;
    if (access && !pready_r) begin
      prdata_nxt = (map_ok && !pwrite_in) ? rd_val : 32'h0000_0000;
    end
    esel_nxt = esel_r;
    cfg_nxt = cfg_r;
    wr_ctr = 4'h0;
    if (commit && paddr_in == bpe_pkg::OFF_ESEL_FIRST) begin
      esel_nxt[0] = bpe_pkg::merge(esel_r[0], pwdata_in, pstrb_in, bpe_pkg::ESEL_RW_MASK);
    end
    if (commit && paddr_in == bpe_pkg::OFF_ESEL_SECOND) begin
      esel_nxt[1] = bpe_pkg::merge(esel_r[1], pwdata_in, pstrb_in, bpe_pkg::ESEL_RW_MASK);
    end
    for (int k = 0; k < bpe_pkg::NUM_CTR; k++) begin
      ctr_nxt[k] = inc[k] ? ctr_r[k] + bpe_cnt_t'(1) : ctr_r[k];
      if (commit && paddr_in == bpe_pkg::OFF_CFG_BASE + 8'(4 * k)) begin
        cfg_nxt[k] = bpe_pkg::merge(cfg_r[k], pwdata_in, pstrb_in, bpe_pkg::CFG_RW_MASK);
      end
      // Software preset wins over a same-cycle count
      if (commit && paddr_in == bpe_pkg::OFF_CTR_BASE + 8'(4 * k)) begin
        wr_ctr[k] = 1'b1;
        ctr_nxt[k] = bpe_cnt_t'(bpe_pkg::merge(32'(ctr_r[k]), pwdata_in, pstrb_in,
                                               32'hffff_ffff));
      end
    end
    tick_nxt = inc;
  end

  // Reset loads constants only, so no reset-time path reaches the data inputs
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < bpe_pkg::NUM_ESEL; i++) begin
        esel_r[i] <= bpe_pkg::ESEL_RESET;
      end
      for (int k = 0; k < bpe_pkg::NUM_CTR; k++) begin
        cfg_r[k] <= bpe_pkg::CFG_RESET;
        ctr_r[k] <= '0;
      end
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      tick_r <= 4'h0;
    end else begin
      esel_r <= esel_nxt;
      cfg_r <= cfg_nxt;
      ctr_r <= ctr_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign prdata_out = prdata_r;
  assign pready_out = pready_r;
  assign pslverr_out = pslverr_r;
  assign ctr_tick_out = tick_r;

  sel_gate_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (!wr_ctr[2] && cfg_r[2][15:13] != 3'h3) |=> $stable(ctr_r[2]))
    else $error("counter 2 moved without bus select");
  first_only_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (inc[1] |-> hit[0]) and (inc[3] |-> hit[1]))
    else $error("counter fed by the wrong selector");
  count_step_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (inc[0] && !wr_ctr[0]) |=> (ctr_r[0] == bpe_cnt_t'($past(ctr_r[0]) + 1'b1)) && ctr_tick_out[0])
    else $error("counter 0 did not step by one");
  apb_wait_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (access && !pready_r) |=> pready_r ##1 !pready_r)
    else $error("pready not a single cycle after one wait");
  b2b_count_c: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
    inc[0] && bpe_pkg::esel_code(esel_r[0]) == bpe_pkg::CODE_B2B);
  second_count_c: cover property (@(posedge mclk_in) disable iff (!rst_n_in) inc[3]);
  bad_addr_c: cover property (@(posedge mclk_in) disable iff (!rst_n_in) pslverr_r);
  resp_count_c: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
    inc[2] && bpe_pkg::esel_code(esel_r[1]) == RESP_CODE);

  // Error answers carry no data and leave both selectors alone
  err_zero_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    pslverr_out |-> (pready_out && prdata_out == 32'h0000_0000))
    else $error("error answer without pready or with data");
  err_nowrite_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (access && pready_r && !map_ok) |=> ($stable(esel_r[0]) && $stable(esel_r[1])))
    else $error("unmapped write changed a selector");
  wr_zero_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (access && !pready_r && pwrite_in) |=> (prdata_out == 32'h0000_0000))
    else $error("write answer carried data");
  esel_bits_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    ((esel_r[0] | esel_r[1]) & ~bpe_pkg::ESEL_RW_MASK) == 32'h0000_0000)
    else $error("selector holds an unwritable bit");

  // Every counter moves only by one matching step or by a software write
  for (genvar k = 0; k < bpe_pkg::NUM_CTR; k++) begin : g_ctr_chk
    hold_idle_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      (!inc[k] && !wr_ctr[k]) |=> $stable(ctr_r[k]))
      else $error("counter moved without a matching clock");
    tick_step_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      (inc[k] && !wr_ctr[k]) |=>
        (ctr_tick_out[k] && ctr_r[k] == $past(ctr_r[k]) + bpe_cnt_t'(1)))
      else $error("counter did not step by one");
    bus_sel_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      inc[k] |-> (cfg_r[k][15:13] == 3'h3 && (k < 2 ? hit[0] : hit[1])))
      else $error("counter counted without bus select or from the wrong selector");
    cfg_bits_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      (cfg_r[k] & ~bpe_pkg::CFG_RW_MASK) == 32'h0000_0000)
      else $error("config holds an unwritable bit");
  end
endmodule : bpe_top

/* dv/tb_bpe_top.sv */
// Testbench: APB register checks and bus event counting for the bus event selector
`timescale 1ns/1ps
module tb_bpe_top;
  logic mclk_in = 1'h0;
  logic rst_n_in = 1'h0;
  logic psel_in = 1'h0;
  logic penable_in = 1'h0;
  logic pwrite_in = 1'h0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0;
  logic [3:0] pstrb_in = 4'hf;
  logic [15:0] occ [4] = '{16'h0, 16'h0, 16'h0, 16'h0};
  logic [31:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  logic [3:0] ctr_tick_out;
  int error_cnt = 0;
  int total_checks = 0;
  integer seed = 32'hf255;
  logic [33:0] exp_q [$];
  logic [33:0] exp_e;
  int ticks [4];
  logic [5:0] codes [4] = '{bpe_pkg::CODE_B2B, bpe_pkg::CODE_BNR, bpe_pkg::CODE_SNOOP,
                            bpe_pkg::RESP_CODE_DEF};
  logic [15:0] valids [4] = '{bpe_pkg::B2B_VALID, bpe_pkg::BNR_VALID, bpe_pkg::SNOOP_VALID,
                              bpe_pkg::RESP_VALID};

  bpe_top DUT (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .b2b_occ_in(occ[0]),
    .bnr_occ_in(occ[1]), .snoop_occ_in(occ[2]), .resp_occ_in(occ[3]),
    .ctr_tick_out(ctr_tick_out));

  initial begin
    forever #5 mclk_in = ~mclk_in;
  end

  task complete_run;
    $display("Checks %0d, errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  task check(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : check

  // One APB transfer; the monitor judges the response
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
           input logic err);
    int n;
    @(posedge mclk_in);
    psel_in <= 1'h1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    pstrb_in <= s;
    exp_q.push_back({~wr, err, wr ? 32'h0 : d});
    @(posedge mclk_in);
    penable_in <= 1'h1;
    for (n = 0; n < 20; n++) begin
      @(posedge mclk_in);
      if (pready_out === 1'h1) break;
    end
    psel_in <= 1'h0;
    penable_in <= 1'h0;
    if (n == 20) begin
      error_cnt++;
      $display("Error pready expected 1 seen timeout");
      complete_run;
    end
  endtask : apb

  function automatic logic [31:0] mk(input logic [5:0] c, input logic [15:0] m);
    mk = {1'h0, c, m, 9'h000};
  endfunction : mk

  // Monitor: pairs every completed transfer with the oldest note
  always @(posedge mclk_in) begin
    for (int k = 0; k < 4; k++) begin
      if (ctr_tick_out[k] === 1'h1) ticks[k]++;
    end
    if (pready_out === 1'h1) begin
      if (exp_q.size() == 0) begin
        error_cnt++;
        $display("Error apb expected none seen response");
      end else begin
        exp_e = exp_q.pop_front();
        check("pslverr", {31'h0, exp_e[32]}, {31'h0, pslverr_out});
        check("prdata", exp_e[31:0], prdata_out);
      end
    end
  end

  // First selector gets event e, second the next one; counter 3 stays disabled,
  // counter 1 has the bus select on odd runs only
  task run_event(input int e);
    int f;
    int h0;
    int h2;
    logic [15:0] m0;
    logic [15:0] m2;
    logic [15:0] r [4];
    logic [31:0] c1;
    f = (e + 1) % 4;
    m0 = 16'($random(seed));
    m2 = 16'($random(seed));
    c1 = e[0] ? 32'h7000 : 32'h5000;
    apb(1'h1, bpe_pkg::OFF_ESEL_FIRST, mk(codes[e], m0), 4'hf, 1'h0);
    apb(1'h1, bpe_pkg::OFF_ESEL_SECOND, mk(codes[f], m2), 4'hf, 1'h0);
    apb(1'h1, bpe_pkg::OFF_CFG_BASE, 32'h7000, 4'hf, 1'h0);
    apb(1'h1, bpe_pkg::OFF_CFG_BASE + 8'h04, c1, 4'hf, 1'h0);
    apb(1'h1, bpe_pkg::OFF_CFG_BASE + 8'h08, 32'h7000, 4'hf, 1'h0);
    apb(1'h1, bpe_pkg::OFF_CFG_BASE + 8'h0c, 32'h6000, 4'hf, 1'h0);
    for (int k = 0; k < 4; k++) apb(1'h1, bpe_pkg::OFF_CTR_BASE + 8'(4 * k), 32'h0, 4'hf, 1'h0);
    @(posedge mclk_in);
    ticks = '{0, 0, 0, 0};
    h0 = 0;
    h2 = 0;
    repeat (24) begin
      @(posedge mclk_in);
      for (int j = 0; j < 4; j++) begin
        r[j] = 16'($random(seed));
        occ[j] <= r[j];
      end
      if (|(r[e] & m0 & valids[e])) h0++;
      if (|(r[f] & m2 & valids[f])) h2++;
    end
    @(posedge mclk_in);
    for (int j = 0; j < 4; j++) occ[j] <= 16'h0;
    @(posedge mclk_in);
    apb(1'h0, bpe_pkg::OFF_CTR_BASE, 32'(h0), 4'hf, 1'h0);
    apb(1'h0, bpe_pkg::OFF_CTR_BASE + 8'h04, e[0] ? 32'(h0) : 32'h0, 4'hf, 1'h0);
    apb(1'h0, bpe_pkg::OFF_CTR_BASE + 8'h08, 32'(h2), 4'hf, 1'h0);
    apb(1'h0, bpe_pkg::OFF_CTR_BASE + 8'h0c, 32'h0, 4'hf, 1'h0);
    check("tick0", 32'(h0), 32'(ticks[0]));
    check("tick1", e[0] ? 32'(h0) : 32'h0, 32'(ticks[1]));
    check("tick2", 32'(h2), 32'(ticks[2]));
    check("tick3", 32'h0, 32'(ticks[3]));
  endtask : run_event

  initial begin
    repeat (10) @(posedge mclk_in);
    rst_n_in <= 1'h1;
    apb(1'h0, bpe_pkg::OFF_ESEL_FIRST, bpe_pkg::ESEL_RESET, 4'hf, 1'h0);
    apb(1'h0, bpe_pkg::OFF_CFG_BASE, bpe_pkg::CFG_RESET, 4'hf, 1'h0);
    apb(1'h1, bpe_pkg::OFF_ESEL_FIRST, 32'hffff_ffff, 4'hf, 1'h0);
    apb(1'h0, bpe_pkg::OFF_ESEL_FIRST, bpe_pkg::ESEL_RW_MASK, 4'hf, 1'h0);
    // Only lane 1 enabled: bits 15:9 land, the rest stay clear
    apb(1'h1, bpe_pkg::OFF_ESEL_SECOND, 32'hffff_ffff, 4'h2, 1'h0);
    apb(1'h0, bpe_pkg::OFF_ESEL_SECOND, 32'h0000_fe00, 4'hf, 1'h0);
    apb(1'h1, bpe_pkg::OFF_CFG_BASE, 32'hffff_ffff, 4'hf, 1'h0);
    apb(1'h0, bpe_pkg::OFF_CFG_BASE, bpe_pkg::CFG_RW_MASK, 4'hf, 1'h0);
    apb(1'h0, 8'h08, 32'h0, 4'hf, 1'h1);
    apb(1'h1, 8'h30, 32'h1234_5678, 4'hf, 1'h1);
    apb(1'h0, 8'h01, 32'h0, 4'hf, 1'h1);
    for (int e = 0; e < 4; e++) run_event(e);
    repeat (4) @(posedge mclk_in);
    complete_run;
  end
endmodule : tb_bpe_top
